// [design/rces_defines.vh]
// Purpose: shared constants of the serial link error supervisor
// Assumes: included by the design file by bare name
// Notes: offsets are Avalon word addresses
`ifndef RCES_DEFINES_VH
`define RCES_DEFINES_VH
// ==========================================================
// error codes
`define RCES_CODE_CRC 8'h47
`define RCES_CODE_PARITY 8'h48
`define RCES_CODE_OTHER 8'h49
// ==========================================================
// frame check
`define RCES_CRC_INIT 16'hFFFF
`define RCES_CRC_POLY 16'hA001
`define RCES_CRC_ZERO 16'h0000
`define RCES_GAP_BITS 33
`define RCES_MIN_FRAME 4'h4
`define RCES_BCAST_ADDR 8'h00
`define RCES_TERR_LIMIT 4'h8
`define RCES_GOOD_SEEN 2'h2
// ==========================================================
// fault actions
`define RCES_ACT_STOP 2'h0
`define RCES_ACT_DSTOP 2'h1
`define RCES_ACT_RECOV 2'h2
`define RCES_ACT_RUN 2'h3
`define RCES_MAX_TIMEOUT 6'h3C
// ==========================================================
// register map
`define RCES_REG_CFG1 4'h0
`define RCES_REG_CFG2 4'h1
`define RCES_REG_STAT1 4'h2
`define RCES_REG_STAT2 4'h3
`define RCES_REG_CLEAR 4'h4
`define RCES_CFG_RESET 32'h00000001
`define RCES_CFG_STN 7:0
`define RCES_CFG_ACT 9:8
`define RCES_CFG_TMO 21:16
`define RCES_CFG_DLY 31:22
`endif

// [design/rces_top.v]
// Purpose: link error supervisor for two serial slave ports
// Assumes: byte-level receive/transmit logic runs on SYS_CLK
// Notes: registers on Avalon-MM, one wait state per access
// Functional notes
// - logical errors reported by error response code
// - local frame CRC mismatch gives code 71
// - parity mismatch gives code 72
// - framing or overrun gives code 73
// - eight straight transmission errors raise error
// - no response after a transmission error
// - any good frame clears error run
// - disconnected: serial run, two good frames seen
// - disconnection timeout raises error, applies action
// - timeout zero disables, else 1..60 s
// - timer held clear outside disconnection
// - latest error code kept per port
// - action 0 stops at once
// - action 1 stops after delay
// - action 2 trips unless recovered in delay
// - action 3 keeps running
// - hold last command while error persists
// - second port has own settings, own trip
// - check is CRC-16, X16+X15+X2+1
// - sender appends check as last two characters
// - receiver accepts when remainder is zero
// - start FFFF, xor byte, eight right shifts
// - 33 bit-time gap ends a frame
`timescale 1ns/1ps
`include "rces_defines.vh"

// ==========================================================
// per-port supervisor
module rces_port #(
	parameter BIT_CYCLES = 10417,
	parameter TENTHS_PER_SEC = 10
) (
	input wire clk,
	input wire rst_b,
	input wire tenth_tick,
	input wire [31:0] cfg,
	input wire clr,
	input wire [7:0] rx_byte,
	input wire rx_valid,
	input wire rx_parity_err,
	input wire rx_other_err,
	input wire log_err_valid,
	input wire [7:0] log_err_code,
	input wire ser_run,
	input wire tx_start,
	input wire [7:0] tx_byte,
	input wire tx_valid,
	output reg frame_ok_q,
	output reg resp_err_q,
	output reg [7:0] resp_code_q,
	output reg [7:0] last_code_q,
	output reg comm_err_q,
	output reg stop_q,
	output reg trip_q,
	output reg hold_q,
	output reg disc_q,
	output reg [3:0] terr_cnt_q,
	output reg [15:0] tx_crc_q
);
	localparam [23:0] GAP_CYCLES = `RCES_GAP_BITS * BIT_CYCLES;
	localparam [3:0] TPS = TENTHS_PER_SEC;
	localparam [1:0] A_IDLE = 2'h0;
	localparam [1:0] A_DELAY = 2'h1;
	localparam [1:0] A_DONE = 2'h2;

	// bitwise, lsb first, matches the line order of the characters
	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0] b;
		integer i;
		reg [15:0] r;
		begin
			r = c ^ {8'h00, b};
			for (i = 0; i < 8; i = i + 1)
				r = r[0] ? ((r >> 1) ^ `RCES_CRC_POLY) : (r >> 1);
			crc_byte = r;
		end
	endfunction

	reg [23:0] gap_q;
	reg in_frame_q;
	reg [15:0] crc_q;
	reg [3:0] len_q;
	reg [7:0] addr_q;
	reg perr_q;
	reg oerr_q;
	reg [1:0] seen_q;
	reg [5:0] sec_q;
	reg [3:0] tenth_q;
	reg fired_q;
	reg [1:0] act_q;
	reg [9:0] dly_q;

	wire [1:0] act_sel = cfg[`RCES_CFG_ACT];
	wire [5:0] tmo = cfg[`RCES_CFG_TMO];
	wire [9:0] dly = cfg[`RCES_CFG_DLY];
	wire frame_end = in_frame_q & (gap_q == GAP_CYCLES - 24'h1);
	wire local_hit = (addr_q == cfg[`RCES_CFG_STN]) | (addr_q == `RCES_BCAST_ADDR);
	wire crc_good = (crc_q == `RCES_CRC_ZERO);
	wire good = frame_end & ~perr_q & ~oerr_q & crc_good & (len_q >= `RCES_MIN_FRAME);
	wire terr = frame_end & (perr_q | oerr_q | (local_hit & ~crc_good));
	wire run_hit = terr & (terr_cnt_q == `RCES_TERR_LIMIT - 4'h1);
	wire disc = ser_run & (seen_q == `RCES_GOOD_SEEN);
	wire sec_tick = tenth_tick & (tenth_q == TPS - 4'h1);
	wire tmo_hit = disc & ~fired_q & sec_tick & (tmo != 6'h00) & (sec_q + 6'h1 >= tmo);
	wire raise = run_hit | tmo_hit;
	// stop is forced at this edge: holding must not start alongside it
	wire stop_go = ((act_q == A_IDLE) & raise & (act_sel == `RCES_ACT_STOP)) |
		((act_q == A_DELAY) & ~((act_sel == `RCES_ACT_RECOV) & good) & (dly_q >= dly));

	// ==========================================================
	// frame assembly and check
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			gap_q <= 24'h0;
			in_frame_q <= 1'b0;
			crc_q <= `RCES_CRC_INIT;
			len_q <= 4'h0;
			addr_q <= 8'h00;
			perr_q <= 1'b0;
			oerr_q <= 1'b0;
		end
		else if (rx_valid)
		begin
			gap_q <= 24'h0;
			in_frame_q <= 1'b1;
			if (!in_frame_q)
			begin
				crc_q <= crc_byte(`RCES_CRC_INIT, rx_byte);
				len_q <= 4'h1;
				addr_q <= rx_byte;
				perr_q <= rx_parity_err;
				oerr_q <= rx_other_err;
			end
			else
			begin
				crc_q <= crc_byte(crc_q, rx_byte);
				if (len_q != 4'hF)
					len_q <= len_q + 4'h1;
				perr_q <= perr_q | rx_parity_err;
				oerr_q <= oerr_q | rx_other_err;
			end
		end
		else if (in_frame_q)
		begin
			gap_q <= gap_q + 24'h1;
			if (frame_end)
				in_frame_q <= 1'b0;
		end
	end

	// ==========================================================
	// classification, error run, last code
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			frame_ok_q <= 1'b0;
			resp_err_q <= 1'b0;
			resp_code_q <= 8'h00;
			last_code_q <= 8'h00;
			terr_cnt_q <= 4'h0;
			seen_q <= 2'h0;
		end
		else
		begin
			// only good local frames earn a reply; bad ones stay silent
			frame_ok_q <= good & local_hit;
			resp_err_q <= log_err_valid & ~terr;
			if (log_err_valid)
				resp_code_q <= log_err_code;
			if (terr)
			begin
				if (perr_q)
					last_code_q <= `RCES_CODE_PARITY;
				else if (oerr_q)
					last_code_q <= `RCES_CODE_OTHER;
				else
					last_code_q <= `RCES_CODE_CRC;
			end
			else if (log_err_valid)
				last_code_q <= log_err_code;
			if (good)
				terr_cnt_q <= 4'h0;
			else if (terr & (terr_cnt_q != `RCES_TERR_LIMIT))
				terr_cnt_q <= terr_cnt_q + 4'h1;
			if (good & (seen_q != `RCES_GOOD_SEEN))
				seen_q <= seen_q + 2'h1;
		end
	end

	// ==========================================================
	// disconnection timer
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			sec_q <= 6'h00;
			tenth_q <= 4'h0;
			fired_q <= 1'b0;
			disc_q <= 1'b0;
		end
		else
		begin
			disc_q <= disc;
			if (!disc | good)
			begin
				sec_q <= 6'h00;
				tenth_q <= 4'h0;
				fired_q <= 1'b0;
			end
			else if (tenth_tick)
			begin
				tenth_q <= sec_tick ? 4'h0 : tenth_q + 4'h1;
				if (sec_tick & (sec_q != 6'h3F))
					sec_q <= sec_q + 6'h1;
				if (tmo_hit)
					fired_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// fault action
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			comm_err_q <= 1'b0;
			stop_q <= 1'b0;
			trip_q <= 1'b0;
			hold_q <= 1'b0;
			act_q <= A_IDLE;
			dly_q <= 10'h000;
		end
		else
		begin
			// a new error in the cycle of recovery still counts
			if (raise)
				comm_err_q <= 1'b1;
			else if (good)
				comm_err_q <= 1'b0;
			hold_q <= (raise | (comm_err_q & ~good)) & ~stop_q & ~stop_go;
			case (act_q)
			A_IDLE:
			begin
				if (raise)
				begin
					dly_q <= 10'h000;
					case (act_sel)
					`RCES_ACT_STOP:
					begin
						stop_q <= 1'b1;
						trip_q <= 1'b1;
						act_q <= A_DONE;
					end
					`RCES_ACT_DSTOP, `RCES_ACT_RECOV:
						act_q <= A_DELAY;
					default:
						act_q <= A_IDLE;
					endcase
				end
			end
			A_DELAY:
			begin
				if ((act_sel == `RCES_ACT_RECOV) & good)
					act_q <= A_IDLE;
				else if (dly_q >= dly)
				begin
					stop_q <= 1'b1;
					trip_q <= 1'b1;
					act_q <= A_DONE;
				end
				else if (tenth_tick)
					dly_q <= dly_q + 10'h001;
			end
			A_DONE:
			begin
				if (clr)
				begin
					stop_q <= 1'b0;
					trip_q <= 1'b0;
					act_q <= A_IDLE;
				end
			end
			default:
				act_q <= A_IDLE;
			endcase
		end
	end

	// ==========================================================
	// check value for outgoing frames, low byte goes out first
	always @(posedge clk)
	begin
		if (!rst_b | tx_start)
			tx_crc_q <= `RCES_CRC_INIT;
		else if (tx_valid)
			tx_crc_q <= crc_byte(tx_crc_q, tx_byte);
	end
endmodule // rces_port

// ==========================================================
// top: timebase, registers, two ports
module rces_top #(
	parameter BIT1_CYCLES = 10417,
	parameter BIT2_CYCLES = 10417,
	parameter TENTH_CYCLES = 10000000
) (
	input wire SYS_CLK,
	input wire RST_B,
	input wire [3:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	output wire [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	input wire [7:0] RX1_BYTE,
	input wire RX1_VALID,
	input wire RX1_PARITY_ERR,
	input wire RX1_OTHER_ERR,
	input wire LOG1_ERR_VALID,
	input wire [7:0] LOG1_ERR_CODE,
	input wire SER1_RUN,
	input wire TX1_START,
	input wire [7:0] TX1_BYTE,
	input wire TX1_VALID,
	output wire FRAME1_OK,
	output wire RESP1_ERR,
	output wire [7:0] RESP1_CODE,
	output wire STOP1,
	output wire PORT1_COMM_TRIP_INDICATION,
	output wire HOLD1,
	output wire [15:0] TX1_CRC,
	input wire [7:0] RX2_BYTE,
	input wire RX2_VALID,
	input wire RX2_PARITY_ERR,
	input wire RX2_OTHER_ERR,
	input wire LOG2_ERR_VALID,
	input wire [7:0] LOG2_ERR_CODE,
	input wire SER2_RUN,
	input wire TX2_START,
	input wire [7:0] TX2_BYTE,
	input wire TX2_VALID,
	output wire FRAME2_OK,
	output wire RESP2_ERR,
	output wire [7:0] RESP2_CODE,
	output wire STOP2,
	output wire PORT2_COMM_TRIP_INDICATION,
	output wire HOLD2,
	output wire [15:0] TX2_CRC
);
	localparam [23:0] TENTH_LAST = TENTH_CYCLES - 1;
	reg [23:0] div_q;
	reg tenth_q;
	reg [31:0] cfg1_q;
	reg [31:0] cfg2_q;
	reg [1:0] clr_q;
	reg [31:0] rdata_q;
	reg wait_q;
	reg [31:0] rd_d;
	wire [7:0] code1, code2;
	wire err1, err2, disc1, disc2;
	wire [3:0] cnt1, cnt2;
	wire req = AVS_READ | AVS_WRITE;
	wire wr = AVS_WRITE & ~wait_q;
	wire [31:0] wcfg = {AVS_WRITEDATA[31:22],
		(AVS_WRITEDATA[21:16] > `RCES_MAX_TIMEOUT) ? `RCES_MAX_TIMEOUT : AVS_WRITEDATA[21:16],
		AVS_WRITEDATA[15:0]};

	assign AVS_READDATA = rdata_q;
	assign AVS_WAITREQUEST = wait_q;

	// ==========================================================
	// tenth-second enable
	always @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			div_q <= 24'h0;
			tenth_q <= 1'b0;
		end
		else
		begin
			tenth_q <= (div_q == TENTH_LAST);
			div_q <= (div_q == TENTH_LAST) ? 24'h0 : div_q + 24'h1;
		end
	end

	// ==========================================================
	// register slave: read data set up during the wait cycle
	always @*
	begin
		rd_d = 32'h0;
		case (AVS_ADDRESS)
		`RCES_REG_CFG1: rd_d = cfg1_q;
		`RCES_REG_CFG2: rd_d = cfg2_q;
		`RCES_REG_STAT1: rd_d = {16'h0, cnt1, disc1, PORT1_COMM_TRIP_INDICATION, STOP1, err1, code1};
		`RCES_REG_STAT2: rd_d = {16'h0, cnt2, disc2, PORT2_COMM_TRIP_INDICATION, STOP2, err2, code2};
		default: rd_d = 32'h0;
		endcase
	end

	always @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
			cfg1_q <= `RCES_CFG_RESET;
			cfg2_q <= `RCES_CFG_RESET;
			clr_q <= 2'h0;
		end
		else
		begin
			wait_q <= ~(req & wait_q);
			if (req & wait_q)
				rdata_q <= AVS_READ ? rd_d : 32'h0;
			clr_q <= (wr & (AVS_ADDRESS == `RCES_REG_CLEAR)) ? AVS_WRITEDATA[1:0] : 2'h0;
			if (wr & (AVS_ADDRESS == `RCES_REG_CFG1))
				cfg1_q <= wcfg;
			if (wr & (AVS_ADDRESS == `RCES_REG_CFG2))
				cfg2_q <= wcfg;
		end
	end

	// ==========================================================
	// ports
	rces_port #(.BIT_CYCLES(BIT1_CYCLES)) u_port1 (
		.clk(SYS_CLK), .rst_b(RST_B), .tenth_tick(tenth_q), .cfg(cfg1_q), .clr(clr_q[0]),
		.rx_byte(RX1_BYTE), .rx_valid(RX1_VALID), .rx_parity_err(RX1_PARITY_ERR),
		.rx_other_err(RX1_OTHER_ERR), .log_err_valid(LOG1_ERR_VALID),
		.log_err_code(LOG1_ERR_CODE), .ser_run(SER1_RUN), .tx_start(TX1_START),
		.tx_byte(TX1_BYTE), .tx_valid(TX1_VALID), .frame_ok_q(FRAME1_OK),
		.resp_err_q(RESP1_ERR), .resp_code_q(RESP1_CODE), .last_code_q(code1),
		.comm_err_q(err1), .stop_q(STOP1), .trip_q(PORT1_COMM_TRIP_INDICATION),
		.hold_q(HOLD1), .disc_q(disc1), .terr_cnt_q(cnt1), .tx_crc_q(TX1_CRC));

	rces_port #(.BIT_CYCLES(BIT2_CYCLES)) u_port2 (
		.clk(SYS_CLK), .rst_b(RST_B), .tenth_tick(tenth_q), .cfg(cfg2_q), .clr(clr_q[1]),
		.rx_byte(RX2_BYTE), .rx_valid(RX2_VALID), .rx_parity_err(RX2_PARITY_ERR),
		.rx_other_err(RX2_OTHER_ERR), .log_err_valid(LOG2_ERR_VALID),
		.log_err_code(LOG2_ERR_CODE), .ser_run(SER2_RUN), .tx_start(TX2_START),
		.tx_byte(TX2_BYTE), .tx_valid(TX2_VALID), .frame_ok_q(FRAME2_OK),
		.resp_err_q(RESP2_ERR), .resp_code_q(RESP2_CODE), .last_code_q(code2),
		.comm_err_q(err2), .stop_q(STOP2), .trip_q(PORT2_COMM_TRIP_INDICATION),
		.hold_q(HOLD2), .disc_q(disc2), .terr_cnt_q(cnt2), .tx_crc_q(TX2_CRC));
endmodule // rces_top

// [test/rces_host.sv]
// Purpose: host controller model driving one receive link
// Assumes: one byte every two clock cycles, well inside the frame gap
// Notes: fault 0 good, 1 bad check, 2 parity flag, 3 framing flag
`timescale 1ns/1ps
module rces_host #(
	parameter GAP = 140
) (
	input wire clk,
	output logic [7:0] byte_o,
	output logic valid_o,
	output logic par_o,
	output logic oth_o
);
	initial
	begin
		byte_o = 8'h00;
		valid_o = 1'b0;
		par_o = 1'b0;
		oth_o = 1'b0;
	end
	// ==========================================================
	// frame check
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++)
			c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		return c;
	endfunction
	// ==========================================================
	// one query frame
	task automatic send(input logic [7:0] stn, input logic [1:0] fault);
		logic [7:0] f [8];
		logic [15:0] c;
		f = '{stn, 8'h03, 8'h03, 8'h02, 8'h00, 8'h14, 8'h00, 8'h00};
		c = 16'hFFFF;
		for (int i = 0; i < 6; i++)
			c = crc_upd(c, f[i]);
		if (fault == 2'h1)
			c = ~c;
		f[6] = c[7:0];
		f[7] = c[15:8];
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			byte_o <= f[i];
			valid_o <= 1'b1;
			par_o <= (fault == 2'h2) && (i == 3);
			oth_o <= (fault == 2'h3) && (i == 5);
			@(posedge clk);
			valid_o <= 1'b0;
			// released line shows the inverse so a stale byte cannot pass
			byte_o <= ~f[i];
			par_o <= 1'b0;
			oth_o <= 1'b0;
		end
		repeat (GAP) @(posedge clk);
	endtask
endmodule // rces_host

// [test/rces_top_chk.sv]
// Purpose: property checker on the supervisor top ports
// Assumes: bound into every rces_top instance
// Notes: port 1 in depth, port 2 only for its trip pairing
`timescale 1ns/1ps
module rces_top_chk (
	input wire SYS_CLK,
	input wire RST_B,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire AVS_WAITREQUEST,
	input wire LOG1_ERR_VALID,
	input wire [7:0] LOG1_ERR_CODE,
	input wire FRAME1_OK,
	input wire RESP1_ERR,
	input wire [7:0] RESP1_CODE,
	input wire STOP1,
	input wire PORT1_COMM_TRIP_INDICATION,
	input wire HOLD1,
	input wire STOP2,
	input wire PORT2_COMM_TRIP_INDICATION,
	input wire TX1_START,
	input wire TX1_VALID,
	input wire [15:0] TX1_CRC
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);
	// ==========================================================
	// register bus
	bus_answer_a: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
		else $error("request not answered after one wait");
	one_wait_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("wait request low for more than one cycle");
	idle_wait_a: assert property (!(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
		else $error("wait request low with no request");
	// ==========================================================
	// link supervision
	ok_pulse_a: assert property (FRAME1_OK |=> !FRAME1_OK)
		else $error("good frame flag longer than one cycle");
	no_reply_a: assert property (RESP1_ERR |-> $past(LOG1_ERR_VALID))
		else $error("error response without a logical error");
	logic_code_a: assert property (LOG1_ERR_VALID |=> RESP1_ERR && (RESP1_CODE == $past(LOG1_ERR_CODE)))
		else $error("logical error not reported with its code");
	hold_stop_a: assert property (HOLD1 |-> !STOP1)
		else $error("command held while stopped");
	stop_trip_a: assert property ($rose(STOP1) |-> PORT1_COMM_TRIP_INDICATION)
		else $error("port 1 stop without trip");
	port2_trip_a: assert property ($rose(STOP2) |-> PORT2_COMM_TRIP_INDICATION)
		else $error("port 2 stop without trip");
	crc_init_a: assert property (TX1_START && !TX1_VALID |=> TX1_CRC == 16'hFFFF)
		else $error("transmit check not preset to all ones");
endmodule // rces_top_chk

bind rces_top rces_top_chk chk_u (.*);

// [test/test_rces_top.sv]
// Purpose: self-checking bench for the link error supervisor
// Assumes: bit time 4 cycles, one second is 100 cycles
// Notes: port 2 shares the command side inputs of port 1
`timescale 1ns/1ps
module test_rces_top;
	logic SYS_CLK = 1'b0, RST_B = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic [3:0] AVS_ADDRESS = 4'h0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic LOG1_ERR_VALID = 1'b0, SER1_RUN = 1'b0, TX1_START = 1'b0, TX1_VALID = 1'b0;
	logic [7:0] LOG1_ERR_CODE = 8'h00, TX1_BYTE = 8'h00;
	wire LOG2_ERR_VALID = LOG1_ERR_VALID, SER2_RUN = SER1_RUN;
	wire TX2_START = TX1_START, TX2_VALID = TX1_VALID;
	wire [7:0] LOG2_ERR_CODE = LOG1_ERR_CODE, TX2_BYTE = TX1_BYTE;
	wire [31:0] AVS_READDATA;
	wire AVS_WAITREQUEST, FRAME1_OK, RESP1_ERR, STOP1, PORT1_COMM_TRIP_INDICATION, HOLD1;
	wire FRAME2_OK, RESP2_ERR, STOP2, PORT2_COMM_TRIP_INDICATION, HOLD2;
	wire RX1_VALID, RX1_PARITY_ERR, RX1_OTHER_ERR, RX2_VALID, RX2_PARITY_ERR, RX2_OTHER_ERR;
	wire [7:0] RX1_BYTE, RX2_BYTE, RESP1_CODE, RESP2_CODE;
	wire [15:0] TX1_CRC, TX2_CRC;
	int err_total = 0, n_compared = 0, ok1_cnt = 0, ok2_cnt = 0;

	rces_top #(.BIT1_CYCLES(4), .BIT2_CYCLES(4), .TENTH_CYCLES(10)) dut_u (.*);
	rces_host h1_u (.clk(SYS_CLK), .byte_o(RX1_BYTE), .valid_o(RX1_VALID),
		.par_o(RX1_PARITY_ERR), .oth_o(RX1_OTHER_ERR));
	rces_host h2_u (.clk(SYS_CLK), .byte_o(RX2_BYTE), .valid_o(RX2_VALID),
		.par_o(RX2_PARITY_ERR), .oth_o(RX2_OTHER_ERR));

	always #5 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK)
	begin
		if (FRAME1_OK === 1'b1)
			ok1_cnt++;
		if (FRAME2_OK === 1'b1)
			ok2_cnt++;
	end
	// ==========================================================
	// checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic timeout;
		err_total++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		finish_test();
	endtask
	// ==========================================================
	// bus master and waits
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		for (i = 0; i < 20; i++)
		begin
			@(posedge SYS_CLK);
			if (AVS_WAITREQUEST === 1'b0)
				break;
		end
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (i == 20)
			timeout();
	endtask
	task automatic wait_hold;
		int i;
		for (i = 0; i < 400 && HOLD1 !== 1'b1; i++)
			@(posedge SYS_CLK);
		if (i == 400)
			timeout();
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		logic [31:0] q;
		logic [15:0] c;
		logic [7:0] fr [6];
		logic [7:0] codes [4];
		fr = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h00, 8'h14};
		codes = '{8'h01, 8'h02, 8'h03, 8'h07};
		repeat (10) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		bus(1'b0, 4'h0, 32'h0, q);
		chk(q, 32'h00000001);
		bus(1'b0, 4'hF, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, 4'h2, 32'hFFFFFFFF, q);
		bus(1'b0, 4'h2, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, 4'h1, 32'h003F0001, q);
		bus(1'b0, 4'h1, 32'h0, q);
		chk(q, 32'h003C0001);
		// transmit check, bytes back to back
		@(posedge SYS_CLK);
		TX1_START <= 1'b1;
		c = 16'hFFFF;
		foreach (fr[i])
		begin
			@(posedge SYS_CLK);
			TX1_START <= 1'b0;
			TX1_VALID <= 1'b1;
			TX1_BYTE <= fr[i];
			c = h1_u.crc_upd(c, fr[i]);
		end
		@(posedge SYS_CLK);
		TX1_VALID <= 1'b0;
		@(posedge SYS_CLK);
		chk(TX1_CRC, c);
		chk(TX2_CRC, c);
		h1_u.send(8'h01, 2'h0);
		chk(ok1_cnt, 1);
		h1_u.send(8'h07, 2'h0);
		chk(ok1_cnt, 1);
		for (int f = 1; f < 4; f++)
		begin
			h1_u.send(8'h01, f[1:0]);
			bus(1'b0, 4'h2, 32'h0, q);
			chk(q[15:0], {f[3:0], 4'h0, 8'h46 + f[7:0]});
		end
		h1_u.send(8'h07, 2'h1);
		bus(1'b0, 4'h2, 32'h0, q);
		chk(q[15:12], 4'h3);
		h1_u.send(8'h07, 2'h0);
		bus(1'b0, 4'h2, 32'h0, q);
		chk(q[15:12], 4'h0);
		repeat (7) h1_u.send(8'h01, 2'h2);
		chk(STOP1, 1'b0);
		h1_u.send(8'h01, 2'h2);
		chk({STOP1, PORT1_COMM_TRIP_INDICATION}, 2'h3);
		chk(ok1_cnt, 1);
		bus(1'b0, 4'h2, 32'h0, q);
		chk(q[11:0], 12'h748);
		bus(1'b1, 4'h4, 32'h1, q);
		h1_u.send(8'h01, 2'h0);
		chk({STOP1, PORT1_COMM_TRIP_INDICATION, HOLD1}, 3'h0);
		repeat (8) h2_u.send(8'h01, 2'h3);
		chk({STOP2, PORT2_COMM_TRIP_INDICATION, STOP1}, 3'h6);
		chk(HOLD2, 1'b0);
		chk(ok2_cnt, 0);
		bus(1'b0, 4'h3, 32'h0, q);
		chk(q[11:0], 12'h749);
		foreach (codes[i])
		begin
			@(posedge SYS_CLK);
			LOG1_ERR_VALID <= 1'b1;
			LOG1_ERR_CODE <= codes[i];
			@(posedge SYS_CLK);
			LOG1_ERR_VALID <= 1'b0;
			@(posedge SYS_CLK);
			chk({RESP1_ERR, RESP2_ERR}, 2'h3);
			bus(1'b0, 4'h2, 32'h0, q);
			chk(q[7:0], codes[i]);
			chk(RESP2_CODE, codes[i]);
		end
		// link loss, keep running
		bus(1'b1, 4'h0, 32'h00010301, q);
		SER1_RUN <= 1'b1;
		wait_hold();
		chk(STOP1, 1'b0);
		bus(1'b0, 4'h2, 32'h0, q);
		chk(q[11:0], 12'h907);
		h1_u.send(8'h07, 2'h0);
		chk(HOLD1, 1'b0);
		// link loss, stop after half a second
		bus(1'b1, 4'h0, 32'h01410101, q);
		wait_hold();
		repeat (30) @(posedge SYS_CLK);
		chk(STOP1, 1'b0);
		repeat (45) @(posedge SYS_CLK);
		chk({STOP1, PORT1_COMM_TRIP_INDICATION}, 2'h3);
		// link loss, recovery inside three seconds, then none
		bus(1'b1, 4'h4, 32'h1, q);
		bus(1'b1, 4'h0, 32'h07810201, q);
		h1_u.send(8'h01, 2'h0);
		wait_hold();
		h1_u.send(8'h01, 2'h0);
		repeat (300) @(posedge SYS_CLK);
		chk(STOP1, 1'b0);
		repeat (150) @(posedge SYS_CLK);
		chk(STOP1, 1'b1);
		// timeout zero disables detection
		bus(1'b1, 4'h4, 32'h1, q);
		bus(1'b1, 4'h0, 32'h00000001, q);
		h1_u.send(8'h01, 2'h0);
		repeat (300) @(posedge SYS_CLK);
		chk({HOLD1, STOP1}, 2'h0);
		h2_u.send(8'h01, 2'h0);
		chk(ok2_cnt, 1);
		bus(1'b0, 4'h3, 32'h0, q);
		chk(q[15:8], 8'h06);
		finish_test();
	end
endmodule // test_rces_top
